// ===== design/sgmii_regs_pkg.sv
// constants, field layouts and carrier types for the serial MAC-side registers
package sgmii_regs_pkg;

   // ==========================================================================
   // register indices (byte address = index * 4)
   localparam logic [11:0] IDX_CTRL_A   = 12'h608;
   localparam logic [11:0] IDX_STATUS   = 12'h60A;
   localparam logic [11:0] IDX_CTRL_B   = 12'h60C;
   localparam logic [11:0] IDX_INT_STAT = 12'h610;
   localparam logic [11:0] IDX_INT_MASK = 12'h611;

   // ==========================================================================
   // reset values
   localparam logic [15:0] CTRL_A_RST   = 16'h007B;
   localparam logic [15:0] STATUS_RST   = 16'h0000;
   localparam logic [15:0] CTRL_B_RST   = 16'h001B;

   // ==========================================================================
   // control register A fields
   localparam int CA_TXERR_DIS  = 15;
   localparam int CA_ALN_FORCE  = 14;
   localparam int CA_ALN_HI     = 13;
   localparam int CA_ALN_LO     = 10;
   localparam int CA_SER_EN     = 9;
   localparam int CA_RX_INV     = 8;
   localparam int CA_TX_INV     = 7;
   localparam int CA_TMR_HI     = 2;
   localparam int CA_TMR_LO     = 1;
   localparam int CA_NEG_EN     = 0;

   // control register B fields
   localparam int CB_SD_VAL     = 8;
   localparam int CB_SD_EN      = 7;
   localparam int CB_RESTART    = 6;
   localparam int CB_TXL_HI     = 5;
   localparam int CB_TXL_LO     = 3;
   localparam int CB_RXL_HI     = 2;
   localparam int CB_RXL_LO     = 0;

   // interrupt status / mask bits
   localparam int INT_W         = 4;
   localparam int INT_PAGE      = 0;
   localparam int INT_LINK      = 1;
   localparam int INT_DONE      = 2;
   localparam int INT_SYNC      = 3;

   // ==========================================================================
   // negotiation link timer
   localparam logic [1:0] TSEL_1600US = 2'b00;
   localparam logic [1:0] TSEL_2US    = 2'b01;
   localparam logic [1:0] TSEL_800US  = 2'b10;
   localparam logic [1:0] TSEL_11MS   = 2'b11;
   localparam int CLK_PERIOD_NS = 25;
   localparam int LT_1600US_NS  = 1600000;
   localparam int LT_2US_NS     = 2000;
   localparam int LT_800US_NS   = 800000;
   localparam int LT_11MS_NS    = 11000000;
   localparam int LT_1600US_CYC = LT_1600US_NS / CLK_PERIOD_NS;
   localparam int LT_2US_CYC    = LT_2US_NS / CLK_PERIOD_NS;
   localparam int LT_800US_CYC  = LT_800US_NS / CLK_PERIOD_NS;
   localparam int LT_11MS_CYC   = LT_11MS_NS / CLK_PERIOD_NS;
   localparam int TMR_W         = 20;

   // ==========================================================================
   // carriers
   typedef struct packed {
      logic       page_rx;
      logic       link_up;
      logic       neg_done;
      logic       align_ind;
      logic       sync_ok;
      logic [3:0] wb_state;
   } pcs_stat_t;

   typedef struct packed {
      logic       ser_en;
      logic       negotiation_enable;
      logic [1:0] timer_sel;
      logic [2:0] tx_fifo_midpoint_level;
      logic [2:0] rx_fifo_midpoint_level;
   } cfg_t;

endpackage

// ===== design/sgmii_mac_side_ctrl_status.sv
// register bank and control glue for the serial MAC-side interface
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps

// Contract
// - tx error disable bit 15 set suppresses transmit error indication.
// - alignment force bit 14 selects software index over search result.
// - index field 13:10 sets word boundary only while force is set.
// - enable bit 9 gates the serial interface; reset value from strap.
// - receive polarity bit 8 inverts incoming serial data.
// - transmit polarity bit 7 inverts outgoing serial data.
// - timer field 2:1 selects 1.6ms, 2us, 800us or 11ms; reset 01.
// - bit 0 enables negotiation; resets to one.
// - status bit 12 shows a new negotiation page has arrived.
// - status bit 11 shows link up.
// - status bit 10 shows negotiation complete.
// - status bit 8 shows word boundary sync achieved.
// - status bit 9 shows the word boundary align indication.
// - status bits 7:4 show the currently selected boundary index.
// - status bits 3:0 show the word boundary machine state.
// - signal detect force enable replaces lock with force value bit 8.
// - control B bits 5:3 set transmit FIFO midpoint level, reset 3.
// - control B bits 2:0 set receive FIFO midpoint level, reset 3.
module sgmii_mac_side_ctrl_status
   import sgmii_regs_pkg::*;
#(
   parameter int DATA_W     = 10,
   parameter int T1600_CYC  = LT_1600US_CYC,
   parameter int T800_CYC   = LT_800US_CYC,
   parameter int T11MS_CYC  = LT_11MS_CYC
) (
   // clock and reset
   input  wire logic              sys_clk_in,
   input  wire logic              nrst_in,
   // ahb-lite slave
   input  wire logic              hsel_in,
   input  wire logic [31:0]       haddr_in,
   input  wire logic [1:0]        htrans_in,
   input  wire logic              hwrite_in,
   input  wire logic [2:0]        hsize_in,
   input  wire logic [31:0]       hwdata_in,
   input  wire logic              hready_in,
   output logic                   hreadyout_out,
   output logic                   hresp_out,
   output logic [31:0]            hrdata_out,
   // strap and pcs status
   input  wire logic              strap_ser_en_in,
   input  wire pcs_stat_t         pcs_stat_in,
   input  wire logic [3:0]        search_idx_in,
   input  wire logic              cdr_lock_in,
   input  wire logic              tx_err_in,
   // serial data path
   input  wire logic [DATA_W-1:0] rx_ser_in,
   input  wire logic [DATA_W-1:0] tx_ser_in,
   output logic [DATA_W-1:0]      rx_ser_out,
   output logic [DATA_W-1:0]      tx_ser_out,
   // controls toward the pcs
   output cfg_t                   cfg_out,
   output logic [3:0]             align_idx_out,
   output logic                   cdr_lock_out,
   output logic                   tx_err_out,
   output logic                   negotiation_restart_out,
   output logic                   link_timer_done_out,
   // interrupt
   output logic                   irq_out
);

   // =========================================================================
   // bus front end
   logic              addr_ok;
   logic              wr_pend_r;
   logic              rd_pend_r;
   logic [29:0]       addr_r;
   logic              strap_done_r;
   logic [15:0]       ctrl_a_r;
   logic [8:0]        ctrl_b_r;
   logic              restart_r;
   logic [INT_W-1:0]  int_st_r;
   logic [INT_W-1:0]  int_mask_r;
   logic [INT_W-1:0]  int_ev;
   pcs_stat_t         stat_prev_r;
   logic [3:0]        sel_idx;
   logic [15:0]       status_val;
   logic [TMR_W-1:0]  tmr_cnt_r;
   logic [TMR_W-1:0]  tmr_limit;
   logic              tmr_run;
   logic              wr_a;
   logic              wr_b;
   logic              wr_ist;
   logic              wr_imask;

   function automatic logic hit(input logic [29:0] a, input logic [11:0] idx);
      hit = (a == {18'h00000, idx});
   endfunction

   assign addr_ok   = hsel_in & htrans_in[1] & hready_in;
   assign wr_a      = wr_pend_r & hit(addr_r, IDX_CTRL_A);
   assign wr_b      = wr_pend_r & hit(addr_r, IDX_CTRL_B);
   assign wr_ist    = wr_pend_r & hit(addr_r, IDX_INT_STAT);
   assign wr_imask  = wr_pend_r & hit(addr_r, IDX_INT_MASK);
   // one wait state on reads so a write just before is always seen
   assign hreadyout_out = ~rd_pend_r;
   assign hresp_out     = 1'b0;

   // address phase capture
   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r    <= 30'h00000000;
      end else begin
         wr_pend_r <= addr_ok & hwrite_in;
         rd_pend_r <= addr_ok & ~hwrite_in;
         if (addr_ok) begin
            addr_r <= haddr_in[31:2];
         end
      end
   end

   // =========================================================================
   // status assembly
   // force only applies while the force bit is one
   assign sel_idx = ctrl_a_r[CA_ALN_FORCE] ? ctrl_a_r[CA_ALN_HI:CA_ALN_LO]
                                           : search_idx_in;
   assign status_val = {3'b000,
                        pcs_stat_in.page_rx,
                        pcs_stat_in.link_up,
                        pcs_stat_in.neg_done,
                        pcs_stat_in.align_ind,
                        pcs_stat_in.sync_ok,
                        sel_idx,
                        pcs_stat_in.wb_state};

   // read data, registered in the wait cycle; unmapped reads give zero
   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         hrdata_out <= 32'h00000000;
      end else if (rd_pend_r) begin
         if (hit(addr_r, IDX_CTRL_A)) begin
            hrdata_out <= {16'h0000, ctrl_a_r};
         end else if (hit(addr_r, IDX_STATUS)) begin
            hrdata_out <= {16'h0000, status_val};
         end else if (hit(addr_r, IDX_CTRL_B)) begin
            // restart bit always reads back zero
            hrdata_out <= {23'h000000, ctrl_b_r[8:7], 1'b0, ctrl_b_r[5:0]};
         end else if (hit(addr_r, IDX_INT_STAT)) begin
            hrdata_out <= {28'h0000000, int_st_r};
         end else if (hit(addr_r, IDX_INT_MASK)) begin
            hrdata_out <= {28'h0000000, int_mask_r};
         end else begin
            hrdata_out <= 32'h00000000;
         end
      end
   end

   // =========================================================================
   // control register A, enable bit loaded from strap after reset
   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         ctrl_a_r     <= CTRL_A_RST;
         strap_done_r <= 1'b0;
      end else begin
         strap_done_r <= 1'b1;
         if (wr_a) begin
            ctrl_a_r <= hwdata_in[15:0];
         end else if (!strap_done_r) begin
            ctrl_a_r[CA_SER_EN] <= strap_ser_en_in;
         end
      end
   end

   // control register B, restart is a self-clearing pulse
   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         ctrl_b_r  <= CTRL_B_RST[8:0];
         restart_r <= 1'b0;
      end else begin
         restart_r <= wr_b & hwdata_in[CB_RESTART];
         if (wr_b) begin
            ctrl_b_r <= {hwdata_in[8:7], 1'b0, hwdata_in[5:0]};
         end
      end
   end

   assign negotiation_restart_out = restart_r;
   assign cfg_out.ser_en = ctrl_a_r[CA_SER_EN];
   assign cfg_out.negotiation_enable = ctrl_a_r[CA_NEG_EN];
   assign cfg_out.timer_sel = ctrl_a_r[CA_TMR_HI:CA_TMR_LO];
   assign cfg_out.tx_fifo_midpoint_level = ctrl_b_r[CB_TXL_HI:CB_TXL_LO];
   assign cfg_out.rx_fifo_midpoint_level = ctrl_b_r[CB_RXL_HI:CB_RXL_LO];

   // =========================================================================
   // interrupts: page/done on rising edge, link/sync on any change
   assign int_ev[INT_PAGE] = pcs_stat_in.page_rx & ~stat_prev_r.page_rx;
   assign int_ev[INT_LINK] = pcs_stat_in.link_up ^ stat_prev_r.link_up;
   assign int_ev[INT_DONE] = pcs_stat_in.neg_done & ~stat_prev_r.neg_done;
   assign int_ev[INT_SYNC] = pcs_stat_in.sync_ok ^ stat_prev_r.sync_ok;

   // sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         stat_prev_r <= '0;
         int_st_r    <= '0;
         int_mask_r  <= '0;
      end else begin
         stat_prev_r <= pcs_stat_in;
         int_st_r    <= (int_st_r & ~(wr_ist ? hwdata_in[INT_W-1:0] : '0))
                        | int_ev;
         if (wr_imask) begin
            int_mask_r <= hwdata_in[INT_W-1:0];
         end
      end
   end

   assign irq_out = |(int_st_r & int_mask_r);

   // =========================================================================
   // negotiation link timer, free running period while negotiation and the serial interface are both enabled
   always_comb begin
      case (ctrl_a_r[CA_TMR_HI:CA_TMR_LO])
         TSEL_1600US: tmr_limit = TMR_W'(T1600_CYC);
         TSEL_2US:    tmr_limit = TMR_W'(LT_2US_CYC);
         TSEL_800US:  tmr_limit = TMR_W'(T800_CYC);
         TSEL_11MS:   tmr_limit = TMR_W'(T11MS_CYC);
         default:     tmr_limit = TMR_W'(LT_2US_CYC);
      endcase
   end

   assign tmr_run = ctrl_a_r[CA_NEG_EN] & ctrl_a_r[CA_SER_EN];

   // a restart or a disable reloads the timer from zero
   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         tmr_cnt_r           <= '0;
         link_timer_done_out <= 1'b0;
      end else if (!tmr_run || restart_r) begin
         tmr_cnt_r           <= '0;
         link_timer_done_out <= 1'b0;
      end else if (tmr_cnt_r >= tmr_limit - TMR_W'(1)) begin
         tmr_cnt_r           <= '0;
         link_timer_done_out <= 1'b1;
      end else begin
         tmr_cnt_r           <= tmr_cnt_r + TMR_W'(1);
         link_timer_done_out <= 1'b0;
      end
   end

   // =========================================================================
   // data path: error gating, index, lock override, polarity
   // disabled interface drives zero words so nothing stale leaks out
   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         tx_err_out    <= 1'b0;
         align_idx_out <= 4'h0;
         cdr_lock_out  <= 1'b0;
         rx_ser_out    <= '0;
         tx_ser_out    <= '0;
      end else begin
         tx_err_out    <= tx_err_in & ~ctrl_a_r[CA_TXERR_DIS];
         align_idx_out <= sel_idx;
         cdr_lock_out  <= ctrl_b_r[CB_SD_EN] ? ctrl_b_r[CB_SD_VAL]
                                             : cdr_lock_in;
         if (ctrl_a_r[CA_SER_EN]) begin
            rx_ser_out <= rx_ser_in ^ {DATA_W{ctrl_a_r[CA_RX_INV]}};
            tx_ser_out <= tx_ser_in ^ {DATA_W{ctrl_a_r[CA_TX_INV]}};
         end else begin
            rx_ser_out <= '0;
            tx_ser_out <= '0;
         end
      end
   end

   // =========================================================================
   // assertions
   sequence s_restart_wr;
      wr_b && hwdata_in[CB_RESTART];
   endsequence

   sequence s_restart_pulse;
      negotiation_restart_out ##1 !negotiation_restart_out;
   endsequence

   a_txerr_gate: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      $past(nrst_in) |-> tx_err_out ==
         ($past(tx_err_in) && !$past(ctrl_a_r[CA_TXERR_DIS])))
      else $error("tx error gating wrong");

   a_align_select: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      $past(nrst_in) && $past(ctrl_a_r[CA_ALN_FORCE]) |->
         align_idx_out == $past(ctrl_a_r[CA_ALN_HI:CA_ALN_LO]))
      else $error("forced index not used");

   a_align_search: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      $past(nrst_in) && !$past(ctrl_a_r[CA_ALN_FORCE]) |->
         align_idx_out == $past(search_idx_in))
      else $error("search index not used");

   a_rx_polarity: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      $past(nrst_in) && $past(ctrl_a_r[CA_SER_EN]) |->
         rx_ser_out == ($past(rx_ser_in) ^ {DATA_W{$past(ctrl_a_r[CA_RX_INV])}}))
      else $error("rx polarity wrong");

   a_tx_polarity: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      $past(nrst_in) && $past(ctrl_a_r[CA_SER_EN]) |->
         tx_ser_out == ($past(tx_ser_in) ^ {DATA_W{$past(ctrl_a_r[CA_TX_INV])}}))
      else $error("tx polarity wrong");

   a_ser_disabled: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      $past(nrst_in) && !$past(ctrl_a_r[CA_SER_EN]) |->
         rx_ser_out == '0 && tx_ser_out == '0)
      else $error("disabled interface drove data");

   // pulse stands in the cycle after the write; checked only when no second write follows
   a_restart_once: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      s_restart_wr ##1 !wr_b |-> s_restart_pulse)
      else $error("restart pulse wrong");

   a_lock_force: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      $past(nrst_in) && $past(ctrl_b_r[CB_SD_EN]) |->
         cdr_lock_out == $past(ctrl_b_r[CB_SD_VAL]))
      else $error("lock override wrong");

   a_timer_bound: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      tmr_run |-> tmr_cnt_r < tmr_limit || $changed(tmr_limit))
      else $error("link timer overran");

   a_reset_values: assert property (@(posedge sys_clk_in)
      $rose(nrst_in) |-> ctrl_a_r[CA_NEG_EN] &&
         ctrl_a_r[CA_TMR_HI:CA_TMR_LO] == TSEL_2US && ctrl_b_r[5:0] == 6'h1B)
      else $error("reset values wrong");

   a_status_read: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      rd_pend_r && hit(addr_r, IDX_STATUS) && !wr_pend_r |=>
         hrdata_out[15:0] == $past(status_val) && hreadyout_out)
      else $error("status read wrong");

endmodule // sgmii_mac_side_ctrl_status

// ===== testbench/pcs_far_model.sv
// far-side model: pcs status, search index and serial words
`timescale 1ns/10ps
module pcs_far_model
   import sgmii_regs_pkg::*;
#(
   parameter int DATA_W = 10
) (
   // clock
   input  wire logic         sys_clk_in,
   // status commanded by the bench
   input  wire pcs_stat_t    stat_cmd_in,
   input  wire logic [3:0]   idx_cmd_in,
   // toward the block
   output pcs_stat_t         pcs_stat_out,
   output logic [3:0]        search_idx_out,
   output logic              cdr_lock_out,
   output logic              tx_err_out,
   output logic [DATA_W-1:0] rx_ser_out,
   output logic [DATA_W-1:0] tx_ser_out
);
   // ==========================================================================
   // known levels at time zero so nothing reaches the block as unknown
   initial begin
      pcs_stat_out = '0;
      search_idx_out = 4'h0;
      cdr_lock_out = 1'b0;
      tx_err_out = 1'b0;
      rx_ser_out = '0;
      tx_ser_out = '0;
   end

   // fresh words every cycle, so a stuck output register cannot pass
   always @(posedge sys_clk_in) begin
      pcs_stat_out <= stat_cmd_in;
      search_idx_out <= idx_cmd_in;
      cdr_lock_out <= 1'($urandom);
      tx_err_out <= 1'($urandom);
      rx_ser_out <= DATA_W'($urandom);
      tx_ser_out <= DATA_W'($urandom);
   end
endmodule // pcs_far_model

// ===== testbench/tb.sv
// self-checking bench for the serial mac-side register bank
`timescale 1ns/10ps
module tb;
   import sgmii_regs_pkg::*;
   // ==========================================================================
   // signals
   logic        sys_clk_in = 1'b0;
   logic        nrst_in = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [2:0]  hsize = 3'b000;
   logic        strap = 1'b1;
   logic        hreadyout, hresp, lock, terr, rst_p, tdone, irq, lk, te;
   logic [31:0] hrdata, d;
   logic [9:0]  rx_o, tx_o, rx_i, tx_i, p_rx, p_tx;
   logic [3:0]  aidx, sidx, p_sidx;
   logic        p_lock, p_terr;
   logic [3:0]  idx_cmd = 4'h0;
   pcs_stat_t   stat_cmd = '0;
   pcs_stat_t   pstat;
   cfg_t        cfg;
   logic [15:0] a, b;
   int          mismatches = 0;
   int          check_count = 0;
   int          tgap [4] = '{200, 80, 100, 300};

   always #12.5 sys_clk_in = ~sys_clk_in;

   // previous-cycle inputs, since the path outputs lag by one register
   always @(posedge sys_clk_in) begin
      p_rx <= rx_i;
      p_tx <= tx_i;
      p_sidx <= sidx;
      p_lock <= lk;
      p_terr <= te;
   end

   // ==========================================================================
   // design and far-side model
   sgmii_mac_side_ctrl_status #(.DATA_W(10), .T1600_CYC(200),
      .T800_CYC(100), .T11MS_CYC(300)) dut_u (
      .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout),
      .hreadyout_out(hreadyout), .hresp_out(hresp), .hrdata_out(hrdata),
      .strap_ser_en_in(strap), .pcs_stat_in(pstat), .search_idx_in(sidx),
      .cdr_lock_in(lk), .tx_err_in(te), .rx_ser_in(rx_i), .tx_ser_in(tx_i),
      .rx_ser_out(rx_o), .tx_ser_out(tx_o), .cfg_out(cfg),
      .align_idx_out(aidx), .cdr_lock_out(lock), .tx_err_out(terr),
      .negotiation_restart_out(rst_p), .link_timer_done_out(tdone),
      .irq_out(irq));

   pcs_far_model #(.DATA_W(10)) far_u (
      .sys_clk_in(sys_clk_in), .stat_cmd_in(stat_cmd), .idx_cmd_in(idx_cmd),
      .pcs_stat_out(pstat), .search_idx_out(sidx), .cdr_lock_out(lk),
      .tx_err_out(te), .rx_ser_out(rx_i), .tx_ser_out(tx_i));

   // ==========================================================================
   // tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one ahb-lite single transfer; waits on hready, no fixed latency assumed
   task automatic bus(input logic wr, input logic [11:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge sys_clk_in);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= 3'b010;
      haddr <= {18'h0, idx, 2'b00};
      do @(posedge sys_clk_in); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge sys_clk_in); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk("hresp", 32'h0, 32'(hresp));
   endtask

   function automatic logic [31:0] exp_stat(pcs_stat_t s, logic [15:0] c,
                                            logic [3:0] ix);
      return {19'h0, s.page_rx, s.link_up, s.neg_done, s.align_ind,
              s.sync_ok, c[CA_ALN_FORCE] ? c[13:10] : ix, s.wb_state};
   endfunction

   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // watchdog: the whole run needs under two thousand cycles
   initial begin
      repeat (30000) @(posedge sys_clk_in);
      mismatches++;
      end_sim();
   end

   // ==========================================================================
   // main sequence
   initial begin
      void'($urandom(84837));
      repeat (16) @(posedge sys_clk_in);
      nrst_in <= 1'b1;
      repeat (3) @(posedge sys_clk_in);
      // reset values, strap loaded into the enable bit
      bus(0, IDX_CTRL_A, 0, d); chk("ctrl_a_rst", 32'h027B, d);
      bus(0, IDX_CTRL_B, 0, d); chk("ctrl_b_rst", 32'h001B, d);
      chk("cfg_rst", 32'h035B, 32'(cfg));
      bus(1, 12'h7FF, 32'hFFFF, d);
      bus(0, 12'h7FF, 0, d); chk("unmapped", 32'h0, d);
      // register read-back and the live data path, corner values first
      for (int i = 0; i < 6; i++) begin
         a = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
         b = (i == 0) ? 16'hFFFF : 16'($urandom);
         idx_cmd <= 4'($urandom);
         bus(1, IDX_CTRL_A, {16'($urandom), a}, d);
         bus(1, IDX_CTRL_B, 32'(b), d);
         bus(0, IDX_CTRL_A, 0, d); chk("ctrl_a", 32'(a), d);
         bus(0, IDX_CTRL_B, 0, d); chk("ctrl_b", 32'(b & 16'h01BF), d);
         chk("cfg", 32'({a[9], a[0], a[2:1], b[5:0]}), 32'(cfg));
         repeat (2) @(negedge sys_clk_in);
         for (int k = 0; k < 8; k++) begin
            @(negedge sys_clk_in);
            chk("rx_ser", 32'(a[9] ? p_rx ^ {10{a[8]}} : 10'h0), 32'(rx_o));
            chk("tx_ser", 32'(a[9] ? p_tx ^ {10{a[7]}} : 10'h0), 32'(tx_o));
            chk("align", 32'(a[14] ? a[13:10] : p_sidx), 32'(aidx));
            chk("lock", 32'(b[7] ? b[8] : p_lock), 32'(lock));
            chk("tx_err", 32'(p_terr & ~a[15]), 32'(terr));
         end
         // status read-back with random machine state
         stat_cmd <= pcs_stat_t'($urandom);
         repeat (3) @(posedge sys_clk_in);
         bus(0, IDX_STATUS, 0, d);
         chk("status", exp_stat(stat_cmd, a, idx_cmd), d);
      end
      // restart pulses once and reads back as zero
      bus(1, IDX_CTRL_B, 32'h0040, d);
      #1 chk("restart_hi", 32'h1, 32'(rst_p));
      @(posedge sys_clk_in);
      #1 chk("restart_lo", 32'h0, 32'(rst_p));
      bus(0, IDX_CTRL_B, 0, d); chk("restart_rd", 32'h0, d);
      // link timer period for every selection, counter zeroed first
      for (int s = 0; s < 4; s++) begin
         int c;
         bus(1, IDX_CTRL_A, 32'h0200, d);
         bus(1, IDX_CTRL_A, 32'h0201 | 32'(s << 1), d);
         c = 0;
         while (tdone !== 1'b1 && c < 2000) begin
            @(negedge sys_clk_in);
            c++;
         end
         c = 0;
         do begin
            @(negedge sys_clk_in);
            c++;
         end while (tdone !== 1'b1 && c < 2000);
         chk("timer_gap", 32'(tgap[s]), 32'(c));
      end
      // interrupts: raise all four, unmask one, clear in two steps
      stat_cmd <= '0;
      repeat (3) @(posedge sys_clk_in);
      bus(1, IDX_INT_MASK, 0, d);
      bus(1, IDX_INT_STAT, 32'hF, d);
      bus(0, IDX_INT_STAT, 0, d); chk("int_clr", 32'h0, d);
      stat_cmd <= pcs_stat_t'(9'h1D0);
      repeat (3) @(posedge sys_clk_in);
      bus(0, IDX_INT_STAT, 0, d); chk("int_set", 32'hF, d);
      #1 chk("irq_masked", 32'h0, 32'(irq));
      bus(1, IDX_INT_MASK, 32'h2, d);
      #1 chk("irq_on", 32'h1, 32'(irq));
      bus(1, IDX_INT_STAT, 32'hD, d);
      #1 chk("irq_kept", 32'h1, 32'(irq));
      bus(1, IDX_INT_STAT, 32'h2, d);
      #1 chk("irq_off", 32'h0, 32'(irq));
      bus(0, IDX_INT_STAT, 0, d); chk("int_end", 32'h0, d);
      // mid-run reset with the strap low: enable bit must come up clear
      strap <= 1'b0;
      nrst_in <= 1'b0;
      repeat (16) @(posedge sys_clk_in);
      nrst_in <= 1'b1;
      repeat (3) @(posedge sys_clk_in);
      bus(0, IDX_CTRL_A, 0, d); chk("ctrl_a_rst2", 32'h007B, d);
      chk("cfg_rst2", 32'h015B, 32'(cfg));
      chk("rx_off", 32'h0, 32'(rx_o));
      chk("tx_off", 32'h0, 32'(tx_o));
      end_sim();
   end
endmodule // tb
